// >>> shared/irq_ctrl_pkg.sv
`default_nettype none
package irq_ctrl_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] OFF_EDGE   = 8'h00;
  localparam logic [7:0] OFF_CTRL_A = 8'h04;
  localparam logic [7:0] OFF_CTRL_B = 8'h08;
  localparam logic [7:0] OFF_STAT   = 8'h0C;
  localparam logic [7:0] OFF_MASK   = 8'h10;
  localparam logic [7:0] OFF_VEC    = 8'h14;
  // Field positions
  localparam int PIN_A_SEL_LO = 0;
  localparam int PIN_B_SEL_LO = 2;
  localparam int GIE_BIT      = 0;
  localparam int PIN_A_EN_BIT = 1;
  localparam int PIN_B_EN_BIT = 2;
  localparam int ADC_EN_BIT   = 3;
  localparam int PIN_A_F_BIT  = 4;
  localparam int PIN_B_F_BIT  = 5;
  localparam int ADC_F_BIT    = 6;
  localparam int SER_F_BIT    = 7;
  localparam int SER_EN_BIT   = 3;
  localparam int GRP_F_LO     = 4;
  localparam int GRP_EN_LO    = 0;
  // Writable masks and reset values
  localparam logic [7:0] EDGE_WMASK  = 8'h0F;
  localparam logic [7:0] CTRL_A_MASK = 8'h7F;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [5:0] EVT_RESET   = 6'h00;
  // Edge select codes
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Vector codes, fixed priority, highest first
  localparam logic [2:0] VEC_NONE  = 3'h0;
  localparam logic [2:0] VEC_PIN_A = 3'h1;
  localparam logic [2:0] VEC_PIN_B = 3'h2;
  localparam logic [2:0] VEC_ADC   = 3'h3;
  localparam logic [2:0] VEC_GRP0  = 3'h4;
  localparam logic [2:0] VEC_GRP1  = 3'h5;
  localparam logic [2:0] VEC_GRP2  = 3'h6;
  localparam logic [2:0] VEC_SER   = 3'h7;
  localparam int NUM_GRP = 3;
  localparam int GRP_SRC = 4;

  // Peripheral event inputs
  typedef struct packed {
    logic                       adc;
    logic                       serial;
    logic [NUM_GRP*GRP_SRC-1:0] grp_member;
  } src_evt_s;

  // Request offered to the processor core
  typedef struct packed {
    logic       valid;
    logic [2:0] vector;
  } core_req_s;

  // All state of the block
  typedef struct packed {
    logic [7:0]  edge_sel;
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [2:0]  pin_a_sync;
    logic [2:0]  pin_b_sync;
    logic [5:0]  evt_stat;
    logic [5:0]  evt_mask;
    logic [31:0] prdata;
    core_req_s   req;
  } state_s;
endpackage : irq_ctrl_pkg
`default_nettype wire

// >>> core/interrupt_request_control.sv
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module interrupt_request_control
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input  wire  logic                  clk,
  input  wire  logic                  resetn,
  // APB slave
  input  wire  logic                  psel,
  input  wire  logic                  penable,
  input  wire  logic                  pwrite,
  input  wire  logic [7:0]            paddr,
  input  wire  logic [31:0]           pwdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic [31:0]                 prdata,
  // External interrupt pins
  input  wire  logic                  ext_irq_pin_a,
  input  wire  logic                  ext_irq_pin_b,
  // Internal event pulses
  input  wire  irq_ctrl_pkg::src_evt_s src_evt,
  input  wire  logic [NUM_GRP*GRP_SRC-1:0] grp_member_en,
  // Core side
  output irq_ctrl_pkg::core_req_s     core_req,
  input  wire  logic                  core_ack,
  output logic                        irq
);
  import irq_ctrl_pkg::*;

  // Source slots in priority order, highest first
  localparam int SRC_PIN_A = 0;
  localparam int SRC_PIN_B = 1;
  localparam int SRC_ADC   = 2;
  localparam int SRC_GRP0  = 3;
  localparam int SRC_GRP1  = 4;
  localparam int SRC_GRP2  = 5;
  localparam int SRC_SER   = 6;
  localparam int NUM_SRC   = 7;
  // Width of one edge select field
  localparam int SEL_W     = 2;

  // Sticky status bit positions
  localparam int STAT_PIN_A = 0;
  localparam int STAT_PIN_B = 1;
  localparam int STAT_ADC   = 2;
  localparam int STAT_SER   = 3;
  localparam int STAT_GRP0  = 4;
  localparam int STAT_GRP12 = 5;

  state_s cur_ff;
  state_s nxt_ff;

  logic       wr_en;
  logic       rd_en;
  logic [5:0] evt_now;
  logic       pin_a_hit;
  logic       pin_b_hit;
  logic [NUM_GRP-1:0] grp_hit;

  // Named views of the edge and first control fields
  logic [SEL_W-1:0]   pin_a_edge_sel;
  logic [SEL_W-1:0]   pin_b_edge_sel;
  logic               global_irq_enable;
  logic               pin_a_irq_enable;
  logic               pin_b_irq_enable;
  logic               adc_irq_enable;
  logic               pin_a_req_flag;
  logic               pin_b_req_flag;
  logic               adc_req_flag;

  // Named views of the second control fields
  logic               group0_irq_enable;
  logic               group1_irq_enable;
  logic               group2_irq_enable;
  logic               serial_module_irq_enable;
  logic               group0_req_flag;
  logic               group1_req_flag;
  logic               group2_req_flag;
  logic               serial_module_req_flag;

  // Pending sources, chosen request, set and clear masks
  logic [NUM_SRC-1:0] src_pend;
  core_req_s          pick;
  logic [7:0]         set_a;
  logic [7:0]         set_b;
  logic [7:0]         clr_a;
  logic [7:0]         clr_b;

  // Register address check, used for reads and writes
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == OFF_EDGE) || (a == OFF_CTRL_A) || (a == OFF_CTRL_B) ||
                  (a == OFF_STAT) || (a == OFF_MASK) || (a == OFF_VEC);
  endfunction : addr_mapped

  // Edge detector on synchronised pin
  function automatic logic edge_hit(input logic [1:0] sel, input logic [2:0] s);
    logic rise;
    logic fall;
    rise = s[1] & ~s[2];
    fall = ~s[1] & s[2];
    case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default:   edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  // Vector code of one source slot
  function automatic logic [2:0] vec_of(input int k);
    case (k)
      SRC_PIN_A: vec_of = VEC_PIN_A;
      SRC_PIN_B: vec_of = VEC_PIN_B;
      SRC_ADC:   vec_of = VEC_ADC;
      SRC_GRP0:  vec_of = VEC_GRP0;
      SRC_GRP1:  vec_of = VEC_GRP1;
      SRC_GRP2:  vec_of = VEC_GRP2;
      SRC_SER:   vec_of = VEC_SER;
      default:   vec_of = VEC_NONE;
    endcase
  endfunction : vec_of

  // Fixed priority, scanned from the bottom so the lowest slot wins
  function automatic core_req_s pick_vector(input logic [NUM_SRC-1:0] pend);
    pick_vector.valid  = 1'b0;
    pick_vector.vector = VEC_NONE;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (pend[k]) begin
        pick_vector.valid  = 1'b1;
        pick_vector.vector = vec_of(k);
      end
    end
  endfunction : pick_vector

  // First control flags that an acknowledge clears
  function automatic logic [7:0] ack_clear_a(input logic [2:0] vec);
    ack_clear_a = REG_RESET;
    case (vec)
      VEC_PIN_A: ack_clear_a[PIN_A_F_BIT] = 1'b1;
      VEC_PIN_B: ack_clear_a[PIN_B_F_BIT] = 1'b1;
      VEC_ADC:   ack_clear_a[ADC_F_BIT]   = 1'b1;
      VEC_GRP0:  ack_clear_a = REG_RESET;
      VEC_GRP1:  ack_clear_a = REG_RESET;
      VEC_GRP2:  ack_clear_a = REG_RESET;
      VEC_SER:   ack_clear_a = REG_RESET;
      default:   ack_clear_a = REG_RESET;
    endcase
  endfunction : ack_clear_a

  // Second control flags that an acknowledge clears, groups never
  function automatic logic [7:0] ack_clear_b(input logic [2:0] vec);
    ack_clear_b = REG_RESET;
    case (vec)
      VEC_SER:   ack_clear_b[SER_F_BIT] = 1'b1;
      VEC_GRP0:  ack_clear_b = REG_RESET;
      VEC_GRP1:  ack_clear_b = REG_RESET;
      VEC_GRP2:  ack_clear_b = REG_RESET;
      VEC_PIN_A: ack_clear_b = REG_RESET;
      VEC_PIN_B: ack_clear_b = REG_RESET;
      VEC_ADC:   ack_clear_b = REG_RESET;
      default:   ack_clear_b = REG_RESET;
    endcase
  endfunction : ack_clear_b

  // Hardware set mask of the first control register
  function automatic logic [7:0] flag_set_a(input logic pa, input logic pb, input logic ad);
    flag_set_a = REG_RESET;
    flag_set_a[PIN_A_F_BIT] = pa;
    flag_set_a[PIN_B_F_BIT] = pb;
    flag_set_a[ADC_F_BIT]   = ad;
  endfunction : flag_set_a

  // Hardware set mask of the second control register
  function automatic logic [7:0] flag_set_b(input logic sr, input logic [NUM_GRP-1:0] gh);
    flag_set_b = REG_RESET;
    flag_set_b[SER_F_BIT] = sr;
    for (int i = 0; i < NUM_GRP; i++) begin
      flag_set_b[GRP_F_LO + i] = gh[i];
    end
  endfunction : flag_set_b

  // Bus strobes, zero wait state
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_mapped(paddr);

  // Pin edge detection, when sync stage 2 differs from stage 3
  assign pin_a_hit = edge_hit(cur_ff.edge_sel[PIN_A_SEL_LO +: 2], cur_ff.pin_a_sync);
  assign pin_b_hit = edge_hit(cur_ff.edge_sel[PIN_B_SEL_LO +: 2], cur_ff.pin_b_sync);

  // Group flags raised by any enabled member event
  genvar g;
  generate
    for (g = 0; g < NUM_GRP; g++) begin : g_grp
      assign grp_hit[g] = |(src_evt.grp_member[g*GRP_SRC +: GRP_SRC] &
                            grp_member_en[g*GRP_SRC +: GRP_SRC]);
    end
  endgenerate

  // Field views of the edge and first control registers
  assign pin_a_edge_sel           = cur_ff.edge_sel[PIN_A_SEL_LO +: SEL_W];
  assign pin_b_edge_sel           = cur_ff.edge_sel[PIN_B_SEL_LO +: SEL_W];
  assign global_irq_enable        = cur_ff.ctrl_a[GIE_BIT];
  assign pin_a_irq_enable         = cur_ff.ctrl_a[PIN_A_EN_BIT];
  assign pin_b_irq_enable         = cur_ff.ctrl_a[PIN_B_EN_BIT];
  assign adc_irq_enable           = cur_ff.ctrl_a[ADC_EN_BIT];
  assign pin_a_req_flag           = cur_ff.ctrl_a[PIN_A_F_BIT];
  assign pin_b_req_flag           = cur_ff.ctrl_a[PIN_B_F_BIT];
  assign adc_req_flag             = cur_ff.ctrl_a[ADC_F_BIT];

  // Field views of the second control register
  assign group0_irq_enable        = cur_ff.ctrl_b[GRP_EN_LO];
  assign group1_irq_enable        = cur_ff.ctrl_b[GRP_EN_LO + 1];
  assign group2_irq_enable        = cur_ff.ctrl_b[GRP_EN_LO + 2];
  assign serial_module_irq_enable = cur_ff.ctrl_b[SER_EN_BIT];
  assign group0_req_flag          = cur_ff.ctrl_b[GRP_F_LO];
  assign group1_req_flag          = cur_ff.ctrl_b[GRP_F_LO + 1];
  assign group2_req_flag          = cur_ff.ctrl_b[GRP_F_LO + 2];
  assign serial_module_req_flag   = cur_ff.ctrl_b[SER_F_BIT];

  // Pending sources: flag, own enable and global enable
  assign src_pend[SRC_PIN_A] = global_irq_enable & pin_a_req_flag & pin_a_irq_enable;
  assign src_pend[SRC_PIN_B] = global_irq_enable & pin_b_req_flag & pin_b_irq_enable;
  assign src_pend[SRC_ADC]   = global_irq_enable & adc_req_flag & adc_irq_enable;
  assign src_pend[SRC_GRP0]  = global_irq_enable & group0_req_flag & group0_irq_enable;
  assign src_pend[SRC_GRP1]  = global_irq_enable & group1_req_flag & group1_irq_enable;
  assign src_pend[SRC_GRP2]  = global_irq_enable & group2_req_flag & group2_irq_enable;
  assign src_pend[SRC_SER]   = global_irq_enable & serial_module_req_flag &
                               serial_module_irq_enable;

  // Highest pending source becomes the next request
  assign pick = pick_vector(src_pend);

  // Flag sets from pins and peripheral events
  assign set_a = flag_set_a(pin_a_hit, pin_b_hit, src_evt.adc);
  assign set_b = flag_set_b(src_evt.serial, grp_hit);

  // Flags cleared when the core takes the standing request
  assign clr_a = (core_ack && cur_ff.req.valid) ? ack_clear_a(cur_ff.req.vector) : REG_RESET;
  assign clr_b = (core_ack && cur_ff.req.valid) ? ack_clear_b(cur_ff.req.vector) : REG_RESET;

  // Sticky status events, groups one and two share a bit
  assign evt_now[STAT_PIN_A] = pin_a_hit;
  assign evt_now[STAT_PIN_B] = pin_b_hit;
  assign evt_now[STAT_ADC]   = src_evt.adc;
  assign evt_now[STAT_SER]   = src_evt.serial;
  assign evt_now[STAT_GRP0]  = grp_hit[0];
  assign evt_now[STAT_GRP12] = grp_hit[1] | grp_hit[2];

  // Next-state logic
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.pin_a_sync = {cur_ff.pin_a_sync[1:0], ext_irq_pin_a};
    nxt_ff.pin_b_sync = {cur_ff.pin_b_sync[1:0], ext_irq_pin_b};
    // Software writes, unimplemented bits dropped
    if (wr_en) begin
      case (paddr)
        OFF_EDGE:   nxt_ff.edge_sel = pwdata[7:0] & EDGE_WMASK;
        OFF_CTRL_A: nxt_ff.ctrl_a   = pwdata[7:0] & CTRL_A_MASK;
        OFF_CTRL_B: nxt_ff.ctrl_b   = pwdata[7:0];
        OFF_STAT:   nxt_ff.evt_stat = cur_ff.evt_stat & ~pwdata[5:0];
        OFF_MASK:   nxt_ff.evt_mask = pwdata[5:0];
        default:    nxt_ff.evt_stat = cur_ff.evt_stat;
      endcase
    end
    // Core acknowledge clears dedicated-vector flags only
    nxt_ff.ctrl_a = nxt_ff.ctrl_a & ~clr_a;
    nxt_ff.ctrl_b = nxt_ff.ctrl_b & ~clr_b;
    // Hardware sets last, so a set wins over any clear
    nxt_ff.ctrl_a = nxt_ff.ctrl_a | set_a;
    nxt_ff.ctrl_b = nxt_ff.ctrl_b | set_b;
    nxt_ff.evt_stat = nxt_ff.evt_stat | evt_now;
    // Forwarded request, one cycle after flag and enables
    nxt_ff.req = pick;
    // Read data captured in setup phase
    nxt_ff.prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        OFF_EDGE:   nxt_ff.prdata = {24'h00_0000, cur_ff.edge_sel};
        OFF_CTRL_A: nxt_ff.prdata = {24'h00_0000, cur_ff.ctrl_a};
        OFF_CTRL_B: nxt_ff.prdata = {24'h00_0000, cur_ff.ctrl_b};
        OFF_STAT:   nxt_ff.prdata = {26'h000_0000, cur_ff.evt_stat};
        OFF_MASK:   nxt_ff.prdata = {26'h000_0000, cur_ff.evt_mask};
        OFF_VEC:    nxt_ff.prdata = {28'h000_0000, cur_ff.req.valid, cur_ff.req.vector};
        default:    nxt_ff.prdata = 32'h0000_0000;
      endcase
    end else begin
      nxt_ff.prdata = cur_ff.prdata;
    end
  end

  // State register, all zero at reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs
  assign prdata   = cur_ff.prdata;
  assign core_req = cur_ff.req;
  assign irq      = |(cur_ff.evt_stat & cur_ff.evt_mask);
endmodule : interrupt_request_control
`default_nettype wire

// >>> tb/irq_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module irq_core_model (
  // Clock, reset and request
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire irq_ctrl_pkg::core_req_s core_req,
  input  wire logic                    ack_go,
  output logic                         core_ack
);
  import irq_ctrl_pkg::*;
  logic [1:0] gap_ff;
  // One ack, then a pause while the flag clears
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_ack <= 1'b0;
      gap_ff   <= 2'h0;
    end else begin
      core_ack <= core_req.valid && ack_go && !core_ack && gap_ff == 2'h0;
      gap_ff   <= core_ack ? 2'h3 : (gap_ff == 2'h0 ? 2'h0 : gap_ff - 2'h1);
    end
  end
endmodule : irq_core_model
`default_nettype wire

// >>> tb/irq_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module irq_asserts (
  // Clock, reset and APB
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic                    pslverr,
  input wire logic [31:0]             prdata,
  // Core side
  input wire irq_ctrl_pkg::core_req_s core_req,
  input wire logic                    core_ack
);
  import irq_ctrl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Read setup at one offset; pin A taken by the core
  sequence s_rd(a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence s_ack_a;
    core_ack && core_req == {1'b1, VEC_PIN_A};
  endsequence
  // Bus and request relations
  property p_err; psel && penable && paddr > OFF_VEC |-> pslverr; endproperty
  property p_edge; s_rd(OFF_EDGE) |=> prdata[31:4] == '0; endproperty
  property p_ctla; s_rd(OFF_CTRL_A) |=> prdata[31:7] == '0; endproperty
  property p_ctlb; s_rd(OFF_CTRL_B) |=> prdata[31:8] == '0; endproperty
  property p_hole; psel && !penable && !pwrite && paddr > OFF_VEC |=> prdata == '0; endproperty
  property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  property p_vec; core_req.valid |-> core_req.vector != VEC_NONE; endproperty
  property p_ack; s_ack_a |=> ##1 core_req != {1'b1, VEC_PIN_A}; endproperty
  a_err: assert property (p_err) else $error("no slave error");
  a_edge: assert property (p_edge) else $error("edge high bits");
  a_ctla: assert property (p_ctla) else $error("ctrl a high bits");
  a_ctlb: assert property (p_ctlb) else $error("ctrl b high bits");
  a_hole: assert property (p_hole) else $error("hole read");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_vec: assert property (p_vec) else $error("empty vector");
  a_ack: assert property (p_ack) else $error("flag kept");
endmodule : irq_asserts
bind interrupt_request_control irq_asserts i_chk (.clk, .resetn, .psel, .penable, .pwrite,
  .paddr, .pslverr, .prdata, .core_req, .core_ack);
`default_nettype wire

// >>> tb/test_interrupt_request_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_request_control;
  import irq_ctrl_pkg::*;
  logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, ack_go = 0;
  logic        pready, pslverr, irq, core_ack, err;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [1:0]  pins = '0;
  logic [11:0] men = '0;
  src_evt_s    evt = '0;
  core_req_s   core_req;
  int          mismatches = 0, tests_run = 0;
  always #5 clk = ~clk;
  interrupt_request_control i_dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata, .ext_irq_pin_a(pins[0]), .ext_irq_pin_b(pins[1]),
    .src_evt(evt), .grp_member_en(men), .core_req, .core_ack, .irq);
  irq_core_model i_core (.clk, .resetn, .core_req, .ack_go, .core_ack);
  // Verdict and compare
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, waiting for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n == 20) begin
      mismatches++;
      give_verdict;
    end
  endtask : apb
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, '0);
    chk(rd, e);
  endtask : rdc
  // Waits, event pulses and pin moves
  task wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wt
  task pulse(input src_evt_s e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
  endtask : pulse
  task pin(input int p, input logic v);
    @(posedge clk);
    pins[p] <= v;
    wt(6);
  endtask : pin
  // Main sequence
  initial begin
    int p, m;
    repeat (2) @(posedge clk);
    resetn <= 1;
    for (p = 0; p <= 16; p += 4) rdc(8'(p), '0);
    apb(1, OFF_EDGE, 32'hFF);
    rdc(OFF_EDGE, 32'h0F);
    apb(1, OFF_CTRL_A, 32'hFF);
    rdc(OFF_CTRL_A, 32'h7F);
    chk(32'(err), 32'h0);
    apb(1, OFF_CTRL_A, '0);
    rdc(8'h18, '0);
    chk(32'(err), 32'h1);
    $display("test reset and reserved done");
    for (p = 0; p < 2; p++)
      for (m = 0; m < 4; m++) begin
        apb(1, OFF_EDGE, 32'(m << (2 * p)));
        pin(p, 1);
        rdc(OFF_CTRL_A, 32'((m & 1) << (4 + p)));
        apb(1, OFF_CTRL_A, '0);
        pin(p, 0);
        rdc(OFF_CTRL_A, 32'((m >> 1) << (4 + p)));
        apb(1, OFF_CTRL_A, '0);
      end
    $display("test edges done");
    apb(1, OFF_EDGE, 32'h01);
    apb(1, OFF_CTRL_A, 32'h0A);
    pulse(14'h2000);
    wt(2);
    chk(core_req, '0);
    rdc(OFF_CTRL_A, 32'h4A);
    apb(1, OFF_CTRL_A, 32'h4B);
    wt(2);
    chk(core_req, {1'b1, VEC_ADC});
    pin(0, 1);
    chk(core_req, {1'b1, VEC_PIN_A});
    @(posedge clk);
    ack_go <= 1;
    wt(12);
    chk(core_req, '0);
    rdc(OFF_CTRL_A, 32'h0B);
    $display("test priority done");
    apb(1, OFF_CTRL_B, 32'h0A);
    men <= 12'h010;
    pulse(14'h1011);
    wt(2);
    rdc(OFF_CTRL_B, 32'hAA);
    chk(core_req, {1'b1, VEC_GRP1});
    apb(1, OFF_CTRL_B, '0);
    wt(2);
    chk(core_req, '0);
    apb(1, OFF_CTRL_A, '0);
    apb(1, OFF_STAT, 32'h3F);
    pulse(14'h2000);
    rdc(OFF_STAT, 32'h04);
    chk(irq, '0);
    apb(1, OFF_MASK, 32'h04);
    wt(2);
    chk(irq, 32'h1);
    apb(1, OFF_STAT, 32'h04);
    wt(2);
    chk(irq, '0);
    $display("test groups and irq done");
    give_verdict;
  end
endmodule : test_interrupt_request_control
`default_nettype wire
